// ===== core/clock_ctrl_pkg.sv
// constants for the synchronous clock prescaler control
// assumes one main clock and a plain register port
package clock_ctrl_pkg;
    // ----------------------------------------
    // register map (plain port addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CPU_SEL = 8'h00;
    localparam logic [7:0] ADDR_PBUS_SEL = 8'h01;
    localparam logic [7:0] ADDR_HS_MASK = 8'h08;
    localparam logic [7:0] ADDR_PBUS_MASK = 8'h09;
    localparam logic [7:0] ADDR_INT_FLAG = 8'h10;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h11;
    localparam logic [7:0] ADDR_STATUS = 8'h12;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int DIV_W = 3;
    localparam int PRESC_W = 8;
    localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
    localparam int POWER_MGR_MASK_BIT = 1;
    localparam int FLAG_READY_BIT = 0;
    localparam int CAUSE_POR_BIT = 0;
    localparam logic [7:0] CAUSE_RESET = 8'h01;
    localparam logic [PRESC_W-1:0] BOUNDARY = 8'h7F;
    localparam int MAX_COMMIT_WAIT = 128;
endpackage

// ===== core/sync_clock_prescaler_control.sv
// synchronous clock prescaler control with gated module branches
// assumes supply_stable and main_clock_ready come from other domains
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Function
// - power manager bus clock off until reset
// - one shared 8-bit prescaler feeds all clocks
// - stopped processor clock runs no instructions
// - high-speed bus follows processor, runs in sleep
// - gate per high-speed bus module branch
// - peripheral clocks divided, run during sleep
// - gate per peripheral bus module branch
// - debugger halt leaves control logic running
// - debug mode keeps all clocks in sleep
// - writable registers honour write protection
// - debugger writes bypass write protection
// - power-on sets cause bit, active mode
// - main clock ready before processor starts
// - reset selects undivided main clock
// - block always enabled, no disable
// - processor rate is main over 2^div
// - peripheral rate is main over 2^div
// - selects writable while modules keep running
// - new dividers apply to all together
// - unchanged divider keeps its rate
// - system reset held until supply stable
// - ratios from 1 up to 128
// - ready low until change effective
// - mask bit stops or restores branch
module sync_clock_prescaler_control #(
    parameter int NUM_PBUS = 3,
    parameter int PBUS_MODULES = 8,
    parameter int HS_MODULES = 8,
    parameter logic [HS_MODULES-1:0] HS_MASK_RESET = 8'hFF,
    parameter logic [NUM_PBUS*PBUS_MODULES-1:0] PBUS_MASK_RESET =
        24'h0000FF
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic write_protect,
    input wire logic debug_access,
    input wire logic debug_mode,
    input wire logic sleep_request,
    input wire logic supply_stable,
    input wire logic main_clock_ready,
    output logic [31:0] read_data,
    output logic cpu_clock_en,
    output logic hsbus_clock_en,
    output logic [HS_MODULES-1:0] hsbus_module_en,
    output logic [NUM_PBUS-1:0] pbus_clock_en,
    output logic [NUM_PBUS*PBUS_MODULES-1:0] pbus_module_en,
    output logic clock_ready,
    output logic system_reset
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (NUM_PBUS < 1 || NUM_PBUS > 7) begin : g_bad_bus
        $error("NUM_PBUS must be 1 to 7");
    end
    if (PBUS_MODULES <= clock_ctrl_pkg::POWER_MGR_MASK_BIT ||
        PBUS_MODULES > 32 || HS_MODULES < 1 ||
        HS_MODULES > 32) begin : g_bad_mod
        $error("module counts out of range");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef logic [clock_ctrl_pkg::DIV_W-1:0] div_t;
    typedef struct packed {
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic [clock_ctrl_pkg::PRESC_W-1:0] cnt;
        div_t cpu_div;
        div_t cpu_new;
        logic [NUM_PBUS-1:0][clock_ctrl_pkg::DIV_W-1:0] pb_div;
        logic [NUM_PBUS-1:0][clock_ctrl_pkg::DIV_W-1:0] pb_new;
        logic pending;
        logic [HS_MODULES-1:0] hs_mask;
        logic [NUM_PBUS-1:0][PBUS_MODULES-1:0] pb_mask;
        logic [7:0] cause;
        logic booted;
        logic sys_reset;
        logic cpu_en;
        logic hs_en;
        logic [HS_MODULES-1:0] hs_mod_en;
        logic [NUM_PBUS-1:0] pb_en;
        logic [NUM_PBUS-1:0][PBUS_MODULES-1:0] pb_mod_en;
        logic ready;
        logic [31:0] rdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic cpu_tick;
    logic [NUM_PBUS-1:0] pb_tick;
    logic boundary;
    logic pm_clock_on;

    // tick when the low div bits of the prescaler are all ones
    function automatic logic tick_at(
        input logic [clock_ctrl_pkg::PRESC_W-1:0] cnt,
        input div_t div);
        logic [clock_ctrl_pkg::PRESC_W-1:0] m;
        m = clock_ctrl_pkg::PRESC_W'((9'h001 << div) - 9'h001);
        return (cnt & m) == m;
    endfunction

    // ----------------------------------------
    // divided clock ticks
    // ----------------------------------------
    // all branches tap the one shared counter
    assign cpu_tick = tick_at(state_r.cnt, state_r.cpu_div);
    genvar gi;
    for (gi = 0; gi < NUM_PBUS; gi++) begin : g_pbus
        assign pb_tick[gi] =
            tick_at(state_r.cnt, state_r.pb_div[gi]);
    end
    // all-ones low bits is an edge of every ratio
    assign boundary = state_r.cnt[6:0] == clock_ctrl_pkg::BOUNDARY[6:0];
    assign pm_clock_on =
        state_r.pb_mask[0][clock_ctrl_pkg::POWER_MGR_MASK_BIT];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic wr_ok;
        logic prot_ok;
        logic [31:0] rd;
        wr_ok = 1'b0;
        prot_ok = 1'b0;
        rd = 32'h0;
        state_nxt = state_r;
        // two-flop synchronisers for the foreign levels
        state_nxt.sync_a = {state_r.sync_a[0], supply_stable};
        state_nxt.sync_b = {state_r.sync_b[0], main_clock_ready};
        state_nxt.sys_reset = !state_r.sync_a[1];
        // processor waits for the calibrated main clock
        if (state_r.sync_b[1] && !state_r.sys_reset) begin
            state_nxt.booted = 1'b1;
        end
        // free running shared prescaler, never disabled
        state_nxt.cnt = state_r.cnt + 8'h01;
        // commit all new dividers together on a boundary
        if (state_r.pending && boundary) begin
            state_nxt.cpu_div = state_r.cpu_new;
            state_nxt.pb_div = state_r.pb_new;
            state_nxt.pending = 1'b0;
        end
        // register writes; no access once own clock is off
        wr_ok = write_strobe && pm_clock_on;
        prot_ok = wr_ok && (!write_protect || debug_access);
        if (prot_ok && !state_r.pending &&
            address == clock_ctrl_pkg::ADDR_CPU_SEL) begin
            state_nxt.cpu_new = write_data[2:0];
            state_nxt.pending = 1'b1;
        end
        for (int i = 0; i < NUM_PBUS; i++) begin
            if (prot_ok &&
                address == clock_ctrl_pkg::ADDR_PBUS_SEL + 8'(i)) begin
                state_nxt.pb_new[i] = write_data[2:0];
                state_nxt.pending = 1'b1;
                // a write on the commit edge joins that commit
                if (state_r.pending && boundary) begin
                    state_nxt.pb_div[i] = write_data[2:0];
                    state_nxt.pending = 1'b0;
                end
            end
            if (prot_ok &&
                address == clock_ctrl_pkg::ADDR_PBUS_MASK + 8'(i)) begin
                state_nxt.pb_mask[i] =
                    write_data[PBUS_MODULES-1:0];
            end
        end
        if (prot_ok && address == clock_ctrl_pkg::ADDR_HS_MASK) begin
            state_nxt.hs_mask = write_data[HS_MODULES-1:0];
        end
        state_nxt.ready = !state_nxt.pending;
        // processor stops in sleep unless debugging
        state_nxt.cpu_en = cpu_tick && state_r.booted &&
            (!sleep_request || debug_mode);
        state_nxt.hs_en = cpu_tick;
        state_nxt.hs_mod_en = {HS_MODULES{cpu_tick}} &
            state_r.hs_mask;
        state_nxt.pb_en = pb_tick;
        for (int i = 0; i < NUM_PBUS; i++) begin
            state_nxt.pb_mod_en[i] = {PBUS_MODULES{pb_tick[i]}} &
                state_r.pb_mask[i];
        end
        // read mux, data valid in the next cycle only
        case (address)
            clock_ctrl_pkg::ADDR_CPU_SEL: rd = 32'(state_r.cpu_new);
            clock_ctrl_pkg::ADDR_HS_MASK: rd = 32'(state_r.hs_mask);
            clock_ctrl_pkg::ADDR_INT_FLAG:
                rd[clock_ctrl_pkg::FLAG_READY_BIT] = state_r.ready;
            clock_ctrl_pkg::ADDR_RESET_CAUSE: rd = 32'(state_r.cause);
            clock_ctrl_pkg::ADDR_STATUS:
                rd = {29'h0, state_r.sys_reset, state_r.booted,
                    state_r.pending};
            default: rd = 32'h0;
        endcase
        for (int i = 0; i < NUM_PBUS; i++) begin
            if (address == clock_ctrl_pkg::ADDR_PBUS_SEL + 8'(i)) begin
                rd = 32'(state_r.pb_new[i]);
            end
            if (address == clock_ctrl_pkg::ADDR_PBUS_MASK + 8'(i)) begin
                rd = 32'(state_r.pb_mask[i]);
            end
        end
        state_nxt.rdata = (read_strobe && pm_clock_on) ? rd : 32'h0;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= '0;
            state_r.cpu_div <= clock_ctrl_pkg::DIV_RESET;
            state_r.cpu_new <= clock_ctrl_pkg::DIV_RESET;
            state_r.hs_mask <= HS_MASK_RESET;
            state_r.pb_mask <= PBUS_MASK_RESET;
            state_r.cause <= clock_ctrl_pkg::CAUSE_RESET;
            state_r.sys_reset <= 1'b1;
            state_r.ready <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state flops
    assign read_data = state_r.rdata;
    assign cpu_clock_en = state_r.cpu_en;
    assign hsbus_clock_en = state_r.hs_en;
    assign hsbus_module_en = state_r.hs_mod_en;
    assign pbus_clock_en = state_r.pb_en;
    assign pbus_module_en = state_r.pb_mod_en;
    assign clock_ready = state_r.ready;
    assign system_reset = state_r.sys_reset;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_pm_clock_locked: assert property (
        !pm_clock_on |=> !pm_clock_on)
        else $error("power manager clock came back");
    a_cpu_sleep_stop: assert property (
        sleep_request && !debug_mode |=> !cpu_clock_en)
        else $error("processor clock ran in sleep");
    a_hsbus_follows_cpu: assert property (
        cpu_tick && !state_r.sys_reset |=> hsbus_clock_en)
        else $error("high-speed bus missed a tick");
    a_hs_branch_gate: assert property (
        hsbus_module_en[0] |-> hsbus_clock_en && $past(state_r.hs_mask[0]))
        else $error("high-speed branch ran ungated");
    a_pbus_branch_gate: assert property (
        pbus_module_en[0] |-> pbus_clock_en[0])
        else $error("peripheral branch ran without bus clock");
    a_debug_sleep_run: assert property (
        debug_mode && sleep_request && cpu_tick && state_r.booted
        |=> cpu_clock_en)
        else $error("clock stopped in debug sleep");
    a_protected_write: assert property (
        write_strobe && write_protect && !debug_access &&
        !state_r.pending && address == clock_ctrl_pkg::ADDR_CPU_SEL
        |=> !state_r.pending)
        else $error("protected write took effect");
    a_debug_write: assert property (
        write_strobe && debug_access && pm_clock_on &&
        address == clock_ctrl_pkg::ADDR_HS_MASK
        |=> state_r.hs_mask == $past(write_data[HS_MODULES-1:0]))
        else $error("debugger write was blocked");
    a_reset_defaults: assert property (
        $fell(reset) |-> state_r.cpu_div == clock_ctrl_pkg::DIV_RESET &&
        state_r.cause[clock_ctrl_pkg::CAUSE_POR_BIT])
        else $error("wrong state after reset");
    a_boot_hold: assert property (
        !state_r.booted |=> !cpu_clock_en)
        else $error("processor clocked before main clock ready");
    a_supply_hold: assert property (
        !state_r.sync_a[1] |=> system_reset)
        else $error("reset released while supply unstable");
    a_commit_bound: assert property (
        $rose(state_r.pending) |-> ##[1:128] !state_r.pending)
        else $error("divider change never took effect");
    a_commit_edge: assert property (
        $fell(state_r.pending) |-> $past(boundary))
        else $error("divider switched off boundary");
    // tick outputs and branch gates
    a_hs_no_extra: assert property (
        !cpu_tick |=> !hsbus_clock_en)
        else $error("high-speed bus ticked off rate");
    a_pbus_tick_out: assert property (
        pb_tick[0] && !state_r.sys_reset |=> pbus_clock_en[0])
        else $error("peripheral bus missed a tick");
    a_pbus_no_extra: assert property (
        !pb_tick[0] |=> !pbus_clock_en[0])
        else $error("peripheral bus ticked off rate");
    a_hs_mask_off: assert property (
        !state_r.hs_mask[0] |=> !hsbus_module_en[0])
        else $error("masked high-speed branch ran");
    a_pbus_mask_off: assert property (
        !state_r.pb_mask[0][0] |=> !pbus_module_en[0])
        else $error("masked peripheral branch ran");
    a_undiv_run: assert property (
        state_r.cpu_div == clock_ctrl_pkg::DIV_RESET && state_r.booted &&
        !sleep_request |=> cpu_clock_en)
        else $error("undivided processor clock skipped");
    a_presc_runs: assert property (
        state_r.cnt != 8'h00 |=> state_r.cnt == $past(state_r.cnt) + 8'h01)
        else $error("shared prescaler stalled");
    // divider updates and register access
    a_div_hold: assert property (
        !state_r.pending |=> $stable(state_r.cpu_div) &&
        $stable(state_r.pb_div))
        else $error("divider changed with nothing pending");
    a_commit_all: assert property (
        state_r.pending && boundary |=>
        state_r.cpu_div == $past(state_r.cpu_new) && clock_ready)
        else $error("dividers did not commit together");
    a_cpu_sel_refused: assert property (
        state_r.pending && write_strobe &&
        address == clock_ctrl_pkg::ADDR_CPU_SEL |=> $stable(state_r.cpu_new))
        else $error("processor select rewritten while pending");
    a_no_access_off: assert property (
        !pm_clock_on |=> read_data == 32'h0)
        else $error("register read with own clock off");

    c_divider_commit: cover property (
        state_r.pending ##[1:128] clock_ready);
    c_debug_sleep: cover property (
        debug_mode && sleep_request && cpu_clock_en);
    c_mask_off: cover property ($fell(hsbus_module_en[0]));
    c_sel_refused: cover property (state_r.pending && write_strobe &&
        address == clock_ctrl_pkg::ADDR_CPU_SEL);
endmodule // sync_clock_prescaler_control

// ===== testbench/clock_source_model.sv
// far side: supply monitor, main clock source and a processor
// assumes it shares the main clock with the block under test
`timescale 1ns/1ps
module clock_source_model #(
    parameter int STABLE_DELAY = 20,
    parameter int CAL_DELAY = 30
) (
    input wire logic clock,
    input wire logic cpu_clock_en,
    output logic supply_stable,
    output logic main_clock_ready,
    output int instr_count
);
    // ----------------------------------------
    // power-up sequence and instruction counter
    // ----------------------------------------
    int age = 0;
    int n_instr = 0;
    // supply settles, then the oscillator is calibrated
    always @(posedge clock) begin
        age <= age + 1;
    end
    assign supply_stable = (age >= STABLE_DELAY);
    assign main_clock_ready = (age >= CAL_DELAY);
    // one instruction per processor tick, none without it
    always @(posedge clock) begin
        if (cpu_clock_en) begin
            n_instr <= n_instr + 1;
        end
    end
    assign instr_count = n_instr;
endmodule // clock_source_model

// ===== testbench/tb_top.sv
// self-checking bench for the clock prescaler control
// assumes the design package and far-side model compile first
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic [7:0] address = 8'h00;
    logic [31:0] write_data = 32'h0;
    logic write_strobe = 1'h0, read_strobe = 1'h0, write_protect = 1'h0;
    logic debug_access = 1'h0, debug_mode = 1'h0, sleep_request = 1'h0;
    logic supply_stable, main_clock_ready, cpu_clock_en, hsbus_clock_en;
    logic clock_ready, system_reset;
    logic [31:0] read_data;
    logic [7:0] hsbus_module_en;
    logic [2:0] pbus_clock_en;
    logic [23:0] pbus_module_en;
    int instr_count, hs_n, p0_n, p1_n, cpu_n;
    int n_mismatch = 0;
    int cmp_count = 0;
    // ----------------------------------------
    // clock, design and far side
    // ----------------------------------------
    always #12.5 clock = ~clock;
    sync_clock_prescaler_control dut_u (
        .clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .write_protect(write_protect),
        .debug_access(debug_access), .debug_mode(debug_mode),
        .sleep_request(sleep_request), .supply_stable(supply_stable),
        .main_clock_ready(main_clock_ready), .read_data(read_data),
        .cpu_clock_en(cpu_clock_en), .hsbus_clock_en(hsbus_clock_en),
        .hsbus_module_en(hsbus_module_en), .pbus_clock_en(pbus_clock_en),
        .pbus_module_en(pbus_module_en), .clock_ready(clock_ready),
        .system_reset(system_reset));
    clock_source_model model_u (
        .clock(clock), .cpu_clock_en(cpu_clock_en),
        .supply_stable(supply_stable), .main_clock_ready(main_clock_ready),
        .instr_count(instr_count));
    // ----------------------------------------
    // access and checking tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write; protect and debugger levels ride along
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic p = 1'h0, input logic g = 1'h0);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_protect <= p;
        debug_access <= g;
        write_strobe <= 1'h1;
        @(posedge clock);
        write_strobe <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'h1;
        @(posedge clock);
        read_strobe <= 1'h0;
        #1;
        check($sformatf("reg %h", a), exp, read_data);
    endtask
    task automatic wait_ready();
        #1;
        for (int k = 0; k < 140 && clock_ready !== 1'h1; k++) begin
            @(posedge clock);
            #1;
        end
        check("clock_ready", 32'h1, clock_ready);
    endtask
    task automatic wait_sys();
        for (int k = 0; k < 60 && system_reset !== 1'h0; k++) begin
            @(posedge clock);
            #1;
        end
        check("system_reset", 32'h0, system_reset);
    endtask
    // processor and peripheral selects taken together
    task automatic set_div(input logic [31:0] cd, input logic [31:0] pd);
        wr(clock_ctrl_pkg::ADDR_CPU_SEL, cd);
        #1;
        check("ready_low", 32'h0, clock_ready);
        wr(clock_ctrl_pkg::ADDR_PBUS_SEL, pd);
        wait_ready();
    endtask
    // count processor, high-speed bus and peripheral bus 0 and 1 ticks over a window
    task automatic run(input int n);
        int c0;
        c0 = instr_count;
        hs_n = 0;
        p0_n = 0;
        p1_n = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            hs_n += hsbus_clock_en;
            p0_n += pbus_clock_en[0];
            p1_n += pbus_clock_en[1];
        end
        cpu_n = instr_count - c0;
    endtask
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        repeat (6) @(posedge clock);
        #1;
        check("held_reset", 32'h1, system_reset);
        wait_sys();
        check("no_early_instr", 32'h0, instr_count);
        repeat (20) @(posedge clock);
        rd_chk(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h0);
        rd_chk(clock_ctrl_pkg::ADDR_PBUS_SEL, 32'h0);
        rd_chk(clock_ctrl_pkg::ADDR_HS_MASK, 32'hFF);
        rd_chk(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'hFF);
        rd_chk(clock_ctrl_pkg::ADDR_RESET_CAUSE, 32'h1);
        rd_chk(clock_ctrl_pkg::ADDR_STATUS, 32'h2);
        rd_chk(clock_ctrl_pkg::ADDR_INT_FLAG, 32'h1);
        rd_chk(8'h3F, 32'h0);
        run(32);
        check("cpu_undivided", 32, cpu_n);
        check("pbus_undivided", 32, p0_n);
        // protected write ignored, debugger write lands
        wr(clock_ctrl_pkg::ADDR_HS_MASK, 32'h0F, 1'h1, 1'h0);
        rd_chk(clock_ctrl_pkg::ADDR_HS_MASK, 32'hFF);
        wr(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h3, 1'h1, 1'h0);
        rd_chk(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h0);
        wr(clock_ctrl_pkg::ADDR_HS_MASK, 32'h0F, 1'h1, 1'h1);
        rd_chk(clock_ctrl_pkg::ADDR_HS_MASK, 32'h0F);
        check("hs_branch", 32'h0F, hsbus_module_en);
        wr(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'hFB);
        rd_chk(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'hFB);
        check("pbus_branch", 32'hFB, pbus_module_en[7:0]);
        wr(clock_ctrl_pkg::ADDR_HS_MASK, 32'hFF);
        // every ratio on the shared prescaler, bus 1 left alone
        wr(clock_ctrl_pkg::ADDR_PBUS_SEL + 8'h01, 32'h7);
        wait_ready();
        for (int d = 0; d < 8; d++) begin
            set_div(d, d);
            run(256);
            check("cpu_rate", 256 >> d, cpu_n);
            check("hs_rate", 256 >> d, hs_n);
            check("pbus0_rate", 256 >> d, p0_n);
            check("pbus1_rate", 2, p1_n);
        end
        // second processor select while pending is dropped
        wr(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h2);
        wr(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h5);
        wait_ready();
        rd_chk(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h2);
        // sleep stops only the processor unless debugging
        @(posedge clock);
        sleep_request <= 1'h1;
        repeat (4) @(posedge clock);
        run(256);
        check("cpu_sleep", 0, cpu_n);
        check("hs_sleep", 64, hs_n);
        check("pbus_sleep", 2, p0_n);
        @(posedge clock);
        debug_mode <= 1'h1;
        repeat (4) @(posedge clock);
        run(256);
        check("cpu_debug", 64, cpu_n);
        rd_chk(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h2);
        @(posedge clock);
        sleep_request <= 1'h0;
        debug_mode <= 1'h0;
        // own bus clock off stays off until reset
        wr(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'hFD, 1'h0, 1'h1);
        wr(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'hFF, 1'h0, 1'h1);
        rd_chk(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'h0);
        check("own_bit", 32'h0, pbus_module_en[1]);
        @(posedge clock);
        reset <= 1'h1;
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        wait_sys();
        repeat (10) @(posedge clock);
        rd_chk(clock_ctrl_pkg::ADDR_PBUS_MASK, 32'hFF);
        rd_chk(clock_ctrl_pkg::ADDR_CPU_SEL, 32'h0);
        end_sim();
    end
endmodule // tb_top
